//--- design/tac_pkg.sv
// Constants, field layout and bus carrier for the timer channel control block
package tac_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int CNT_W = 16;
  // Register addresses
  localparam logic [11:0] ADDR_DATA_A_LO = 12'h02D;
  localparam logic [11:0] ADDR_DATA_A_HI = 12'h02E;
  localparam logic [11:0] ADDR_DATA_B_LO = 12'h02F;
  localparam logic [11:0] ADDR_DATA_B_HI = 12'h030;
  localparam logic [11:0] ADDR_MODE = 12'h031;
  localparam logic [11:0] ADDR_CONTROL = 12'h032;
  localparam logic [11:0] ADDR_STATUS = 12'h033;
  localparam logic [11:0] ADDR_CLOCK_GATE = 12'hF74;
  // Reset values
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_CLOCK_GATE = 8'h00;
  localparam logic [15:0] RST_DATA = 16'hFFFF;
  // Clock gate bits
  localparam int GATE_CHAN0 = 0;
  localparam int GATE_CHAN1 = 1;
  localparam int GATE_GRP01 = 4;
  localparam int GATE_GRP23 = 5;
  // Mode register fields
  localparam int MODE_DBE = 7;
  localparam int MODE_POL = 6;
  localparam int MODE_STYLE = 5;
  localparam int MODE_CK_HI = 4;
  localparam int MODE_CK_LO = 3;
  localparam int MODE_OP_HI = 2;
  localparam int MODE_OP_LO = 0;
  // Control register fields
  localparam int CTL_OVE = 7;
  localparam int CTL_TFF = 6;
  localparam int CTL_NC_HI = 5;
  localparam int CTL_NC_LO = 4;
  localparam int CTL_ACAP = 1;
  localparam int CTL_RUN = 0;
  localparam logic [7:0] CTL_READ_MASK = 8'hF3;
  localparam logic [7:0] CTL_LOCK_MASK = 8'hF0;
  // Status register fields
  localparam int STAT_OVF = 7;
  localparam int STAT_CPFA = 1;
  localparam int STAT_CPFB = 0;
  // Operating modes
  localparam logic [2:0] OP_TIMER0 = 3'h0;
  localparam logic [2:0] OP_TIMER1 = 3'h1;
  localparam logic [2:0] OP_EVENT = 3'h2;
  localparam logic [2:0] OP_PPG = 3'h3;
  localparam logic [2:0] OP_TRIG = 3'h4;
  localparam logic [2:0] OP_WINDOW = 3'h5;
  localparam logic [2:0] OP_PWM = 3'h6;
  // Source clock and filter sample shifts, low-frequency divide
  localparam int SHIFT_CK0 = 10;
  localparam int SHIFT_CK1 = 6;
  localparam int SHIFT_CK2 = 2;
  localparam int SHIFT_CK3 = 1;
  localparam int SHIFT_NC1 = 1;
  localparam int SHIFT_NC2 = 2;
  localparam int SHIFT_NC3 = 8;
  localparam int PSC_W = 11;
  localparam logic [2:0] LF_DIV8_LAST = 3'h7;

  typedef struct packed {
    logic [11:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tac_bus_s;
endpackage : tac_pkg

//--- design/tac_timer_ctrl.sv
// Control, configuration and counting logic of one 16-bit timer channel
// What this block does
// - Channel set up by clock gate, mode, control and two 16-bit data registers.
// - Eight-bit clock-gate register, one enable per group, all zero after reset.
// - Double-buffer bit routes data writes through a shadow buffer when set.
// - Trigger polarity 0 rising/high, 1 falling/low on the timer input.
// - Pulse width measurement: style 0 double-edge, 1 single-edge capture.
// - External trigger: 0 start only, 1 active edge starts, opposite stops.
// - Source select gear/2^10,/2^6,/2^2,/2; code 00 low-freq/8 when selected.
// - Mode field selects timer, event, PPG, trigger, window, pulse width; 111 reserved.
// - Mode register writes ignored while running.
// - Overflow raises the interrupt only when overflow enable is set.
// - Preset, overflow enable and filter field writable only while stopped.
// - Filter 00 off; 01,10,11 sample at gear/2,/4,/256; slow 11 low-freq/2.
// - In slow modes filter codes 01 and 10 block the input entirely.
// - Auto capture works only in timer, event, trigger and window modes.
// - Run bit starts the counter; writing 0 stops and clears it.
// - Entering STOP clears the run bit and halts the timer.
// - Control register bits 3 and 2 read as zero.
// - Low-byte write held in temp; high-byte write commits 16 bits.
// - Status flags clear on status read; writes to status do nothing.
//
// The address-and-strobe port was left to the implementer.
module tac_timer_ctrl (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Register port
  input wire tac_pkg::tac_bus_s bus,
  output logic [tac_pkg::DATA_W-1:0] rdata,
  // Power mode controls
  input wire logic lowfreq_divider_sel,
  input wire logic slow_mode,
  input wire logic stop_entry,
  // Pins
  input wire logic low_freq_clock,
  input wire logic timer_in,
  output logic ppg_out,
  output logic timer_irq
);
  import tac_pkg::*;

  function automatic logic div_tick(input logic [PSC_W-1:0] p, input int sh);
    logic [PSC_W-1:0] m;
    m = PSC_W'((1 << sh) - 1);
    return (p & m) == m;
  endfunction

  function automatic logic [7:0] pick_byte(input logic [15:0] v, input logic hi);
    return hi ? v[15:8] : v[7:0];
  endfunction

  typedef enum logic [1:0] {PW_IDLE, PW_HIGH, PW_LOW} tac_pw_e;

  logic [7:0] gate_r, mode_r, ctl_r;
  logic [15:0] cnt_r, data_a_r, data_b_r, shadow_a_r, shadow_b_r;
  logic [7:0] temp_a_r, temp_b_r;
  logic ovf_r, cpfa_r, cpfb_r;
  logic [PSC_W-1:0] psc_r;
  logic [2:0] lf_div_r;
  logic lf_half_r;
  logic [1:0] lf_sync_r, in_sync_r;
  logic lf_last_r;
  logic filt_r, samp_r, act_last_r;
  logic armed_r;
  tac_pw_e pw_r;
  logic irq_nxt;

  logic clk_on, running, wr_mode, wr_ctl, rd_stat, pw_mode;
  logic [2:0] op;
  logic lf_edge, lf8_tick, src_tick, samp_tick, filt_on;
  logic active, act_rise, act_fall, cnt_en, match_a, match_b, ovf_evt;
  logic cap_a, cap_b, cnt_clear, acap_on, ppg_mode, oneshot_end;

  assign clk_on = gate_r[GATE_CHAN0];
  assign running = ctl_r[CTL_RUN];
  assign op = mode_r[MODE_OP_HI:MODE_OP_LO];
  assign pw_mode = (op == OP_PWM);
  assign ppg_mode = (op == OP_PPG);
  assign wr_mode = bus.wr && bus.addr == ADDR_MODE && clk_on && !running;
  assign wr_ctl = bus.wr && bus.addr == ADDR_CONTROL && clk_on;
  assign rd_stat = bus.rd && bus.addr == ADDR_STATUS;

  // Clock gate register, never itself gated
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      gate_r <= RST_CLOCK_GATE;
    end else if (bus.wr && bus.addr == ADDR_CLOCK_GATE) begin
      gate_r <= bus.wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mode_r <= RST_MODE;
    end else if (wr_mode) begin
      mode_r <= bus.wdata;
    end
  end

  // Locked fields keep their value while running; run bit writable with the channel clock on, but stop entry wins
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ctl_r <= RST_CONTROL;
    end else if (stop_entry || (oneshot_end && !wr_ctl)) begin
      ctl_r[CTL_RUN] <= 1'b0;
    end else if (wr_ctl) begin
      if (running) begin
        ctl_r <= (ctl_r & CTL_LOCK_MASK) | (bus.wdata & ~CTL_LOCK_MASK);
      end else begin
        ctl_r <= bus.wdata;
      end
    end
  end

  // Pin synchronisers
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      lf_sync_r <= 2'h0;
      in_sync_r <= 2'h0;
      lf_last_r <= 1'b0;
    end else begin
      lf_sync_r <= {lf_sync_r[0], low_freq_clock};
      in_sync_r <= {in_sync_r[0], timer_in};
      lf_last_r <= lf_sync_r[1];
    end
  end
  assign lf_edge = lf_sync_r[1] && !lf_last_r;

  // Prescalers run only while the channel clock is supplied
  always_ff @(posedge core_clk) begin
    if (sys_rst || !clk_on) begin
      psc_r <= '0;
      lf_div_r <= 3'h0;
      lf_half_r <= 1'b0;
    end else begin
      psc_r <= psc_r + PSC_W'(1);
      if (lf_edge) begin
        lf_div_r <= lf_div_r + 3'h1;
        lf_half_r <= !lf_half_r;
      end
    end
  end
  assign lf8_tick = lf_edge && lf_div_r == LF_DIV8_LAST;

  always_comb begin
    unique case (mode_r[MODE_CK_HI:MODE_CK_LO])
      2'h0: src_tick = (lowfreq_divider_sel || slow_mode) ? lf8_tick
                                                         : div_tick(psc_r, SHIFT_CK0);
      2'h1: src_tick = !slow_mode && div_tick(psc_r, SHIFT_CK1);
      2'h2: src_tick = !slow_mode && div_tick(psc_r, SHIFT_CK2);
      2'h3: src_tick = !slow_mode && div_tick(psc_r, SHIFT_CK3);
    endcase
  end

  // Filter: a level passes once two successive samples agree
  always_comb begin
    filt_on = 1'b1;
    unique case (ctl_r[CTL_NC_HI:CTL_NC_LO])
      2'h0: samp_tick = 1'b0;
      2'h1: begin
        samp_tick = div_tick(psc_r, SHIFT_NC1);
        filt_on = !slow_mode;
      end
      2'h2: begin
        samp_tick = div_tick(psc_r, SHIFT_NC2);
        filt_on = !slow_mode;
      end
      2'h3: samp_tick = slow_mode ? (lf_edge && lf_half_r) : div_tick(psc_r, SHIFT_NC3);
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      filt_r <= 1'b0;
      samp_r <= 1'b0;
    end else if (ctl_r[CTL_NC_HI:CTL_NC_LO] == 2'h0) begin
      filt_r <= in_sync_r[1];
      samp_r <= in_sync_r[1];
    end else if (filt_on && samp_tick) begin
      samp_r <= in_sync_r[1];
      if (samp_r == in_sync_r[1]) begin
        filt_r <= samp_r;
      end
    end
  end

  // Blocked filter holds the last level so no edge reaches the counter
  assign active = filt_r ^ mode_r[MODE_POL];
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      act_last_r <= 1'b0;
    end else begin
      act_last_r <= active;
    end
  end
  assign act_rise = active && !act_last_r;
  assign act_fall = !active && act_last_r;

  // External trigger arming
  always_ff @(posedge core_clk) begin
    if (sys_rst || !running || !clk_on) begin
      armed_r <= 1'b0;
    end else if (act_rise) begin
      armed_r <= 1'b1;
    end else if (mode_r[MODE_STYLE] && act_fall) begin
      armed_r <= 1'b0;
    end
  end

  // Pulse width phase
  always_ff @(posedge core_clk) begin
    if (sys_rst || !running || !clk_on || !pw_mode) begin
      pw_r <= PW_IDLE;
    end else begin
      unique case (pw_r)
        PW_IDLE: if (act_rise) pw_r <= PW_HIGH;
        PW_HIGH: if (act_fall && !mode_r[MODE_STYLE]) pw_r <= PW_LOW;
        PW_LOW: if (act_rise) pw_r <= PW_HIGH;
      endcase
    end
  end

  assign cap_a = pw_mode && pw_r == PW_HIGH && act_fall && !mode_r[MODE_STYLE];
  assign cap_b = pw_mode && pw_r != PW_IDLE && act_rise;

  always_comb begin
    cnt_en = 1'b0;
    unique case (op)
      OP_TIMER0, OP_TIMER1, OP_PPG: cnt_en = src_tick;
      OP_EVENT: cnt_en = act_rise;
      OP_TRIG: cnt_en = src_tick && (armed_r || act_rise);
      OP_WINDOW: cnt_en = src_tick && active;
      OP_PWM: cnt_en = src_tick && pw_r != PW_IDLE;
      default: cnt_en = 1'b0;
    endcase
    cnt_en = cnt_en && running && clk_on;
  end

  assign match_a = cnt_en && cnt_r == data_a_r && !pw_mode;
  assign match_b = cnt_en && ppg_mode && cnt_r == data_b_r;
  assign ovf_evt = cnt_en && cnt_r == 16'hFFFF && !(ppg_mode ? match_b : match_a);
  assign oneshot_end = match_b && ctl_r[CTL_ACAP];
  assign cnt_clear = ppg_mode ? match_b : (match_a || cap_b || (pw_mode && act_rise));
  assign acap_on = ctl_r[CTL_ACAP] && (op == OP_TIMER0 || op == OP_TIMER1 ||
                   op == OP_EVENT || op == OP_TRIG || op == OP_WINDOW);

  always_ff @(posedge core_clk) begin
    if (sys_rst || !running) begin
      cnt_r <= 16'h0000;
    end else if (op == OP_TRIG && mode_r[MODE_STYLE] && act_fall) begin
      cnt_r <= 16'h0000;
    end else if (cnt_clear) begin
      cnt_r <= 16'h0000;
    end else if (cnt_en) begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end

  // Output flip-flop: preset while stopped, toggles on a single match A or B in every mode but pulse width
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ppg_out <= 1'b0;
    end else if (!running) begin
      ppg_out <= ctl_r[CTL_TFF];
    end else if (match_a != match_b) begin
      ppg_out <= !ppg_out;
    end
  end

  // Data registers; double buffer loads at counter clear or while stopped
  logic wr_data_ok;
  assign wr_data_ok = bus.wr && clk_on && !pw_mode;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      temp_a_r <= RST_DATA[7:0];
      temp_b_r <= RST_DATA[7:0];
      data_a_r <= RST_DATA;
      data_b_r <= RST_DATA;
      shadow_a_r <= RST_DATA;
      shadow_b_r <= RST_DATA;
    end else begin
      if (wr_data_ok && bus.addr == ADDR_DATA_A_LO) temp_a_r <= bus.wdata;
      if (wr_data_ok && bus.addr == ADDR_DATA_B_LO) temp_b_r <= bus.wdata;
      if (wr_data_ok && bus.addr == ADDR_DATA_A_HI) begin
        if (mode_r[MODE_DBE]) shadow_a_r <= {bus.wdata, temp_a_r};
        else data_a_r <= {bus.wdata, temp_a_r};
      end else if (cap_a) begin
        data_a_r <= cnt_r;
      end else if (mode_r[MODE_DBE] && (cnt_clear || !running)) begin
        data_a_r <= shadow_a_r;
      end
      if (wr_data_ok && bus.addr == ADDR_DATA_B_HI) begin
        if (mode_r[MODE_DBE]) shadow_b_r <= {bus.wdata, temp_b_r};
        else data_b_r <= {bus.wdata, temp_b_r};
      end else if (cap_b || (acap_on && running)) begin
        data_b_r <= cnt_r;
      end else if (mode_r[MODE_DBE] && (cnt_clear || !running)) begin
        data_b_r <= shadow_b_r;
      end
    end
  end

  // Status flags; a new event beats a clearing read
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ovf_r <= 1'b0;
      cpfa_r <= 1'b0;
      cpfb_r <= 1'b0;
    end else begin
      ovf_r <= ovf_evt || (ovf_r && !rd_stat);
      cpfa_r <= cap_a || (cpfa_r && !rd_stat);
      cpfb_r <= cap_b || (cpfb_r && !rd_stat);
    end
  end

  // Interrupt: a single-cycle request per event
  always_comb begin
    irq_nxt = (ovf_evt && ctl_r[CTL_OVE]) || match_a || match_b || cap_a || cap_b;
  end
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      timer_irq <= 1'b0;
    end else begin
      timer_irq <= irq_nxt;
    end
  end

  // Read data one cycle after the strobe, zero otherwise
  always_ff @(posedge core_clk) begin
    if (sys_rst || !bus.rd) begin
      rdata <= 8'h00;
    end else begin
      unique case (bus.addr)
        ADDR_DATA_A_LO: rdata <= pick_byte(data_a_r, 1'b0);
        ADDR_DATA_A_HI: rdata <= pick_byte(data_a_r, 1'b1);
        ADDR_DATA_B_LO: rdata <= pick_byte(data_b_r, 1'b0);
        ADDR_DATA_B_HI: rdata <= pick_byte(data_b_r, 1'b1);
        ADDR_MODE: rdata <= mode_r;
        ADDR_CONTROL: rdata <= ctl_r & CTL_READ_MASK;
        ADDR_STATUS: rdata <= {ovf_r, 5'h00, cpfa_r, cpfb_r};
        ADDR_CLOCK_GATE: rdata <= gate_r;
        default: rdata <= 8'h00;
      endcase
    end
  end
endmodule // tac_timer_ctrl

//--- tb/tac_pin_model.sv
// Pin-side model: timer input driver, low-frequency clock, output watcher
module tac_pin_model (
  // Clock
  input wire logic core_clk,
  // Level asked for by the bench
  input wire logic lvl_req,
  // Pins
  output logic timer_in,
  output logic low_freq_clock,
  input wire logic ppg_out,
  // Output edge count
  output logic [15:0] ppg_toggles
);
  timeunit 1ns;
  timeprecision 100ps;
  logic ppg_q = 1'b0;
  initial begin
    timer_in = 1'b0;
    low_freq_clock = 1'b0;
    ppg_toggles = 16'h0000;
  end
  // Pin moves off the core edge, like a real asynchronous source
  always @(lvl_req) timer_in <= #1.3 lvl_req;
  // Free-running, phase unrelated to the core clock
  always #20.7 low_freq_clock = ~low_freq_clock;
  always @(posedge core_clk) begin
    ppg_q <= ppg_out;
    if (ppg_out !== ppg_q) ppg_toggles <= ppg_toggles + 16'h0001;
  end
endmodule // tac_pin_model

//--- tb/tac_timer_ctrl_properties.sv
// Port-level checks for the timer channel
module tac_ctrl_props (
  // Clock, reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Bus
  input wire tac_pkg::tac_bus_s bus,
  input wire logic [tac_pkg::DATA_W-1:0] rdata,
  // Pins
  input wire logic stop_entry,
  input wire logic ppg_out,
  input wire logic timer_irq
);
  timeunit 1ns;
  timeprecision 100ps;
  import tac_pkg::*;
  logic gate_r;
  // Own copy of the channel gate, to know when the block must be frozen
  always_ff @(posedge core_clk) begin
    if (sys_rst) gate_r <= 1'b0;
    else if (bus.wr && bus.addr == ADDR_CLOCK_GATE) gate_r <= bus.wdata[GATE_CHAN0];
  end
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  idle_rdata_a: assert property (!bus.rd |=> rdata == 8'h00)
    else $error("rdata not zero when idle");
  ctl_gap_a: assert property (bus.rd && bus.addr == ADDR_CONTROL |=> rdata[3:2] == 2'h0)
    else $error("control bits 3:2 not zero");
  stat_gap_a: assert property (bus.rd && bus.addr == ADDR_STATUS |=> rdata[6:2] == 5'h00)
    else $error("status bits 6:2 not zero");
  reset_quiet_a: assert property (disable iff (1'b0) sys_rst |=> !timer_irq && !ppg_out && rdata == 8'h00)
    else $error("outputs active after reset");
  unmapped_zero_a: assert property (bus.rd && bus.addr == 12'h000 |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  stop_clears_a: assert property (stop_entry ##1 (stop_entry && bus.rd && bus.addr == ADDR_CONTROL) |=> !rdata[CTL_RUN])
    else $error("run bit survived stop entry");
  gate_readback_a: assert property (bus.wr && bus.addr == ADDR_CLOCK_GATE ##1 !bus.wr ##1 bus.rd && bus.addr == ADDR_CLOCK_GATE |=> rdata == $past(bus.wdata, 3))
    else $error("gate register readback wrong");
  gate_off_quiet_a: assert property (!gate_r && !$past(gate_r) |-> !timer_irq)
    else $error("interrupt while gated off");
endmodule // tac_ctrl_props

//--- tb/test_tac_timer_ctrl.sv
// Self-checking bench for the timer channel control block
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; $display("ERROR %0t mismatch %h exp %h", $time, g, e); end end
module test_tac_timer_ctrl;
  timeunit 1ns;
  timeprecision 100ps;
  import tac_pkg::*;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  tac_bus_s bus = '0;
  logic stop_entry = 1'b0;
  logic slow_mode = 1'b0;
  logic lf_sel = 1'b0;
  logic lvl = 1'b0;
  logic [7:0] rdata, d, v;
  logic lfc, tin, ppg_out, timer_irq;
  logic [15:0] toggles, base;
  int fail_count = 0, compares = 0, cycles = 0, irqs = 0, t_prev = 0, t_last = 0;
  tac_timer_ctrl uut (.core_clk(core_clk), .sys_rst(sys_rst), .bus(bus), .rdata(rdata),
    .lowfreq_divider_sel(lf_sel), .slow_mode(slow_mode), .stop_entry(stop_entry),
    .low_freq_clock(lfc), .timer_in(tin), .ppg_out(ppg_out), .timer_irq(timer_irq));
  tac_pin_model pins (.core_clk(core_clk), .lvl_req(lvl), .timer_in(tin),
    .low_freq_clock(lfc), .ppg_out(ppg_out), .ppg_toggles(toggles));
  always #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (timer_irq === 1'b1) begin
      irqs++;
      t_prev = t_last;
      t_last = cycles;
    end
    if (cycles == 60000) begin
      fail_count++;
      end_of_test();
    end
  end
  task automatic wr(input logic [11:0] a, input logic [7:0] x);
    @(posedge core_clk);
    bus <= '{addr: a, wdata: x, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus <= '0;
  endtask
  task automatic rd_byte(input logic [11:0] a);
    @(posedge core_clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    bus <= '0;
    #1 d = rdata;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [7:0] e);
    rd_byte(a);
    `CHK(d, e)
  endtask
  // Stop first: mode writes are refused while running
  task automatic cfg(input logic [7:0] m, input logic [7:0] c, input logic [15:0] a);
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_MODE, m);
    wr(ADDR_DATA_A_LO, a[7:0]);
    wr(ADDR_DATA_A_HI, a[15:8]);
    wr(ADDR_CONTROL, c);
  endtask
  task automatic wait_irqs(input int n, input int lim);
    repeat (lim) if (irqs < n) begin
      @(posedge core_clk);
      #1;
    end
  endtask
  // Match at 3 means four source ticks per period
  function automatic int period(input int ck);
    case (ck)
      0: return 4 << SHIFT_CK0;
      1: return 4 << SHIFT_CK1;
      2: return 4 << SHIFT_CK2;
      default: return 4 << SHIFT_CK3;
    endcase
  endfunction
  task automatic end_of_test();
    if (fail_count == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    v = 8'($urandom(35353));
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    rchk(ADDR_CLOCK_GATE, RST_CLOCK_GATE);
    wr(ADDR_MODE, 8'h5A);
    rchk(ADDR_MODE, RST_MODE);
    rchk(ADDR_CONTROL, RST_CONTROL);
    rchk(ADDR_STATUS, 8'h00);
    rchk(12'h000, 8'h00);
    wr(ADDR_CLOCK_GATE, v | 8'h01);
    rchk(ADDR_CLOCK_GATE, v | 8'h01);
    v = 8'($urandom);
    wr(ADDR_DATA_A_LO, v);
    rchk(ADDR_DATA_A_LO, RST_DATA[7:0]);
    wr(ADDR_DATA_A_HI, ~v);
    rchk(ADDR_DATA_A_LO, v);
    rchk(ADDR_DATA_A_HI, ~v);
    for (int op = 0; op < 7; op++) begin
      v = (8'($urandom) & 8'hF8) | 8'(op);
      wr(ADDR_MODE, v);
      rchk(ADDR_MODE, v);
    end
    repeat (6) begin
      v = 8'($urandom) & 8'hFE;
      wr(ADDR_CONTROL, v);
      rchk(ADDR_CONTROL, v & CTL_READ_MASK);
    end
    for (int ck = 0; ck < 4; ck++) begin
      cfg(8'(ck << 3), 8'h01, 16'h0003);
      irqs = 0;
      t_prev = 0;
      t_last = 0;
      wait_irqs(2, 9000);
      `CHK(t_last - t_prev, period(ck))
    end
    wr(ADDR_MODE, 8'h05);
    rchk(ADDR_MODE, 8'h18);
    wr(ADDR_CONTROL, 8'hF1);
    rchk(ADDR_CONTROL, 8'h01);
    @(posedge core_clk);
    stop_entry <= 1'b1;
    rchk(ADDR_CONTROL, 8'h00);
    @(posedge core_clk);
    stop_entry <= 1'b0;
    wr(ADDR_CONTROL, 8'h01);
    wr(ADDR_CONTROL, 8'h00);
    irqs = 0;
    repeat (300) @(posedge core_clk);
    `CHK(irqs, 0)
    // Trigger start on each polarity through every filter setting
    for (int p = 0; p < 2; p++) for (int nc = 0; nc < 4; nc++) begin
      lvl = p[0];
      cfg(8'h1C | 8'(p << 6), 8'(nc << 4), 16'h0003);
      repeat (600) @(posedge core_clk);
      wr(ADDR_CONTROL, 8'(nc << 4) | 8'h01);
      irqs = 0;
      repeat (100) @(posedge core_clk);
      `CHK(irqs, 0)
      lvl = ~p[0];
      wait_irqs(1, 1500);
      `CHK(irqs != 0, 1'b1)
    end
    cfg(8'h1B, 8'h40, 16'h0002);
    wr(ADDR_DATA_B_LO, 8'h05);
    wr(ADDR_DATA_B_HI, 8'h00);
    #1 `CHK(ppg_out, 1'b1)
    base = toggles;
    wr(ADDR_CONTROL, 8'h43);
    repeat (200) @(posedge core_clk);
    `CHK(toggles - base, 16'h0002)
    rchk(ADDR_CONTROL, 8'h42);
    // Pulse width: double edge flags both captures, single edge only B
    for (int s = 0; s < 2; s++) begin
      cfg(8'h1E | 8'(s << 5), 8'h01, 16'h0000);
      rchk(ADDR_STATUS, 8'h00);
      irqs = 0;
      repeat (2) begin
        lvl = 1'b1;
        repeat (40) @(posedge core_clk);
        lvl = 1'b0;
        repeat (40) @(posedge core_clk);
      end
      `CHK(irqs, s ? 1 : 3)
      rchk(ADDR_STATUS, s ? 8'h01 : 8'h03);
      rchk(ADDR_STATUS, 8'h00);
    end
    // Start/stop trigger; auto capture makes the counter visible in data B
    cfg(8'h3C, 8'h03, 16'h0FFF);
    lvl = 1'b1;
    repeat (40) @(posedge core_clk);
    rd_byte(ADDR_DATA_B_LO);
    v = d;
    rd_byte(ADDR_DATA_B_LO);
    `CHK(d > v, 1'b1)
    lvl = 1'b0;
    repeat (10) @(posedge core_clk);
    rd_byte(ADDR_DATA_B_LO);
    v = d;
    repeat (20) @(posedge core_clk);
    rd_byte(ADDR_DATA_B_LO);
    `CHK(d, v)
    // Double buffer: a write while running waits for the next counter clear
    cfg(8'h80, 8'h01, 16'h0003);
    wr(ADDR_DATA_A_LO, 8'h40);
    wr(ADDR_DATA_A_HI, 8'h00);
    irqs = 0;
    rchk(ADDR_DATA_A_LO, 8'h03);
    wait_irqs(1, 5000);
    rchk(ADDR_DATA_A_LO, 8'h40);
    // Slow mode: low-frequency source, filter code 01 blocked, code 11 passing
    @(posedge core_clk);
    slow_mode <= 1'b1;
    cfg(8'h00, 8'h01, 16'h0003);
    irqs = 0;
    t_prev = 0;
    t_last = 0;
    wait_irqs(2, 900);
    `CHK((t_last - t_prev) inside {[262:268]}, 1'b1)
    for (int nc = 1; nc < 4; nc += 2) begin
      cfg(8'h02, 8'(nc << 4) | 8'h01, 16'h0000);
      irqs = 0;
      repeat (2) begin
        lvl = 1'b1;
        repeat (80) @(posedge core_clk);
        lvl = 1'b0;
        repeat (80) @(posedge core_clk);
      end
      `CHK(irqs != 0, nc == 3)
    end
    end_of_test();
  end
endmodule // test_tac_timer_ctrl
bind tac_timer_ctrl tac_ctrl_props chk (.core_clk(core_clk), .sys_rst(sys_rst), .bus(bus),
  .rdata(rdata), .stop_entry(stop_entry), .ppg_out(ppg_out), .timer_irq(timer_irq));
